// file: ccr_dec_if.sv
// Carrier between the register bank and its format and spread decoders.
interface ccr_dec_if;
    import ccr_pkg::*;
    logic [2:0] fmt1;
    logic [2:0] fmt2;
    ccr_pins_s pins1;
    ccr_pins_s pins2;
    logic [2:0] spread_code;
    ccr_spread_e spread;

    modport fmt (input fmt1, input fmt2, output pins1, output pins2);
    modport spr (input spread_code, output spread);
    modport top (output fmt1, output fmt2, output spread_code,
                 input pins1, input pins2, input spread);
endinterface

// file: ccr_defs.svh
// Offsets, field positions, reset values and masks of the output configuration registers.
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ==========================================================================
// Register offsets
`define CCR_OFS_OUTCTL 8'h07
`define CCR_OFS_NUMLO 8'h08
`define CCR_OFS_CFGID 8'h09

// ==========================================================================
// Output pair control fields
`define CCR_POS_PAIR2_EN 8
`define CCR_POS_PAIR2_SRC 7
`define CCR_POS_PAIR2_FMT_HI 4
`define CCR_POS_PAIR2_FMT_LO 2
`define CCR_POS_PAIR1_EN 1
`define CCR_POS_OE_POL 0

// ==========================================================================
// Identifier and spread select fields
`define CCR_POS_ID_HI 15
`define CCR_POS_ID_LO 12
`define CCR_POS_SPREAD_HI 11
`define CCR_POS_SPREAD_LO 9

// ==========================================================================
// Reset values and storage masks
`define CCR_RST_OUTCTL 16'h5D1F
`define CCR_RST_NUMLO 16'hC28F
`define CCR_RST_CFGID 16'h3000
`define CCR_MASK_OUTCTL 16'h7FFF
`define CCR_MASK_CFGID 16'hFFFF

`endif

// file: ccr_fmt_dec.sv
// Output format decoder for both output pairs.
module ccr_fmt_dec
    import ccr_pkg::*;
(
    // Decoder carrier
    ccr_dec_if.fmt dec
);

    // ======================================================================
    // Shared format decode
    // The first pair uses the same encoding, so one function serves both.
    function automatic ccr_pins_s fmt_decode(input logic [2:0] code);
        ccr_pins_s p;
        p = '0;
        case (code)
            3'h4: begin
                p.pin0_en = 1'b1;
            end
            3'h5: begin
                p.pin1_en = 1'b1;
            end
            3'h6: begin
                p.pin0_en = 1'b1;
                p.pin1_en = 1'b1;
                p.pin1_inv = 1'b1;
            end
            3'h7: begin
                p.pin0_en = 1'b1;
                p.pin1_en = 1'b1;
            end
            default: begin
                p = '0;
            end
        endcase
        return p;
    endfunction

    always_comb begin
        dec.pins1 = fmt_decode(dec.fmt1);
        dec.pins2 = fmt_decode(dec.fmt2);
    end

endmodule

// file: ccr_host.sv
// Host model that programs the configuration registers.
module ccr_host (
    // Clock
    input wire logic clk,
    // Register access
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    // Idle bus lines show inverted data so stale values are never trusted.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        if (a == 8'h07) d = d & 16'h7F9F;
        if (a == 8'h09) d = d & 16'hFE00;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] q,
                      output logic v);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        {q, v} = {reg_rdata, reg_rvalid};
        {reg_addr, reg_rd} = {~a, 1'b0};
    endtask
endmodule

// file: ccr_pkg.sv
// Types shared by the output configuration register bank and its decoders.
package ccr_pkg;

    // ======================================================================
    // Decoded pin activity of one output pair
    typedef struct packed {
        logic pin0_en;
        logic pin1_en;
        logic pin1_inv;
    } ccr_pins_s;

    // ======================================================================
    // Spread modulation selection
    typedef enum logic [2:0] {
        spread_custom,
        spread_down_010,
        spread_down_025,
        spread_down_030,
        spread_down_050,
        spread_reserved
    } ccr_spread_e;

endpackage

// file: ccr_spread_dec.sv
// Spread modulation preset decoder.
module ccr_spread_dec
    import ccr_pkg::*;
(
    // Decoder carrier
    ccr_dec_if.spr dec
);

    // ======================================================================
    // Preset decode
    always_comb begin
        case (dec.spread_code)
            3'h0: begin
                dec.spread = spread_custom;
            end
            3'h1: begin
                dec.spread = spread_down_010;
            end
            3'h2: begin
                dec.spread = spread_down_025;
            end
            3'h3: begin
                dec.spread = spread_down_030;
            end
            3'h4: begin
                dec.spread = spread_down_050;
            end
            default: begin
                dec.spread = spread_reserved;
            end
        endcase
    end

endmodule

// file: ccr_top.sv
// Output configuration register bank of the clock generator.
//
// Behaviour
// - Second pair enable bit: 0 disables, 1 enables; resets to 1.
// - Second pair source: 0 channel divider 0, 1 channel divider 1.
// - Second pair format: 0-3 reserved, 4 first pin, 5 second pin; reset 7.
// - First pair enable bit: 0 disables, 1 enables; resets to 1.
// - Enable pin polarity: 0 active high, 1 active low; resets to 1.
// - Polarity inverts only the enable pin, never the pair enable bits.
// - One register holds the low 16 numerator bits; fuse gives reset value.
// - Full 24-bit numerator is high byte above the low 16 bits.
// - Four-bit identifier field is readable, writable spare storage.
// - Spread codes 1-4 select -0.10, -0.25, -0.30, -0.50 percent down.
// - Spread code 0 selects the custom modulation parameters.
// - Every field loads from fuse storage at power-up.
`include "ccr_defs.svh"

module ccr_top
    import ccr_pkg::*;
#(
    parameter logic [15:0] NUMLO_RESET = `CCR_RST_NUMLO,
    parameter logic [15:0] CFGID_RESET = `CCR_RST_CFGID
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Fuse storage load
    input wire logic fuse_load,
    input wire logic [15:0] fuse_outctl,
    input wire logic [15:0] fuse_numlo,
    input wire logic [15:0] fuse_cfgid,
    // Neighbouring register fields
    input wire logic [7:0] numerator_high,
    input wire logic [2:0] pair1_format,
    // External enable pin
    input wire logic oe_pin,
    // Output steering
    output logic oe_active,
    output logic clock_out_a_en,
    output logic clock_out_b_en,
    output logic clock_out_b_invert,
    output logic clock_out_c_en,
    output logic clock_out_d_en,
    output logic clock_out_d_invert,
    output logic pair2_source_select,
    output logic [23:0] frac_divider1_numerator,
    output ccr_spread_e spread_preset,
    output logic spread_custom_sel
);

    // ======================================================================
    // State
    logic [15:0] outctl_q, outctl_d;
    logic [15:0] numlo_q, numlo_d;
    logic [15:0] cfgid_q, cfgid_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic oe_act_q, oe_act_d;
    logic a_en_q, a_en_d;
    logic b_en_q, b_en_d;
    logic b_inv_q, b_inv_d;
    logic c_en_q, c_en_d;
    logic d_en_q, d_en_d;
    logic d_inv_q, d_inv_d;
    logic src_q, src_d;
    logic [23:0] num_q, num_d;
    ccr_spread_e spread_q, spread_d;
    logic custom_q, custom_d;
    logic pair1_on;
    logic pair2_on;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;

    // ======================================================================
    // Decoders
    ccr_dec_if dec ();

    ccr_fmt_dec u_fmt (
        .dec(dec.fmt)
    );

    ccr_spread_dec u_spread (
        .dec(dec.spr)
    );

    assign dec.fmt1 = pair1_format;
    assign dec.fmt2 = outctl_q[`CCR_POS_PAIR2_FMT_HI:`CCR_POS_PAIR2_FMT_LO];
    assign dec.spread_code = cfgid_q[`CCR_POS_SPREAD_HI:`CCR_POS_SPREAD_LO];

    // ======================================================================
    // Address decode
    // Write and read paths share one map so they can never disagree.
    function automatic logic [2:0] reg_select(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        if (addr == `CCR_OFS_OUTCTL) begin
            sel = 3'h1;
        end else if (addr == `CCR_OFS_NUMLO) begin
            sel = 3'h2;
        end else if (addr == `CCR_OFS_CFGID) begin
            sel = 3'h4;
        end
        return sel;
    endfunction

    assign wr_sel = reg_select(reg_addr);

    // ======================================================================
    // Output pair control register
    // A fuse load wins over a host write in the same cycle, since it
    // only happens at power-up before software is running.
    always_comb begin
        outctl_d = outctl_q;
        if (fuse_load) begin
            outctl_d = fuse_outctl & `CCR_MASK_OUTCTL;
        end else if (reg_wr && wr_sel[0]) begin
            // Reserved bits 14:9 and 6:5 are stored as written and bit 15 is cleared; the host keeps 6:5 zero, not 14:9.
            outctl_d = reg_wdata & `CCR_MASK_OUTCTL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outctl_q <= `CCR_RST_OUTCTL;
        end else begin
            outctl_q <= outctl_d;
        end
    end

    // ======================================================================
    // Numerator low register
    always_comb begin
        numlo_d = numlo_q;
        if (fuse_load) begin
            numlo_d = fuse_numlo;
        end else if (reg_wr && wr_sel[1]) begin
            numlo_d = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            numlo_q <= NUMLO_RESET;
        end else begin
            numlo_q <= numlo_d;
        end
    end

    // ======================================================================
    // Identifier and spread select register
    // The identifier has no function in host mode; it is spare storage.
    always_comb begin
        cfgid_d = cfgid_q;
        if (fuse_load) begin
            cfgid_d = fuse_cfgid & `CCR_MASK_CFGID;
        end else if (reg_wr && wr_sel[2]) begin
            cfgid_d = reg_wdata & `CCR_MASK_CFGID;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfgid_q <= CFGID_RESET;
        end else begin
            cfgid_q <= cfgid_d;
        end
    end

    // ======================================================================
    // Read port
    // Registered read data cost a cycle of latency but keep the bus output
    // glitch free; a read beside a write to one address sees the old value.
    always_comb begin
        rd_sel = reg_select(reg_addr);
        rvalid_d = reg_rd;
        rdata_d = 16'h0000;
        if (reg_rd) begin
            if (rd_sel[0]) begin
                rdata_d = outctl_q;
            end else if (rd_sel[1]) begin
                rdata_d = numlo_q;
            end else if (rd_sel[2]) begin
                rdata_d = cfgid_q;
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ======================================================================
    // Enable pin
    always_comb begin
        // The polarity bit flips only the pin; enable bits keep their sense.
        oe_act_d = oe_pin ^ outctl_q[`CCR_POS_OE_POL];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            oe_act_q <= 1'b0;
        end else begin
            oe_act_q <= oe_act_d;
        end
    end

    // ======================================================================
    // First output pair
    always_comb begin
        pair1_on = oe_act_d & outctl_q[`CCR_POS_PAIR1_EN];
        a_en_d = pair1_on & dec.pins1.pin0_en;
        b_en_d = pair1_on & dec.pins1.pin1_en;
        b_inv_d = dec.pins1.pin1_inv;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            a_en_q <= 1'b0;
            b_en_q <= 1'b0;
            b_inv_q <= 1'b0;
        end else begin
            a_en_q <= a_en_d;
            b_en_q <= b_en_d;
            b_inv_q <= b_inv_d;
        end
    end

    // ======================================================================
    // Second output pair
    always_comb begin
        pair2_on = oe_act_d & outctl_q[`CCR_POS_PAIR2_EN];
        c_en_d = pair2_on & dec.pins2.pin0_en;
        d_en_d = pair2_on & dec.pins2.pin1_en;
        d_inv_d = dec.pins2.pin1_inv;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            c_en_q <= 1'b0;
            d_en_q <= 1'b0;
            d_inv_q <= 1'b0;
        end else begin
            c_en_q <= c_en_d;
            d_en_q <= d_en_d;
            d_inv_q <= d_inv_d;
        end
    end

    // ======================================================================
    // Divider and modulation selects
    // Copies of stored fields, registered so every output leaves a flop.
    always_comb begin
        src_d = outctl_q[`CCR_POS_PAIR2_SRC];
        num_d = {numerator_high, numlo_q};
        spread_d = dec.spread;
        custom_d = (dec.spread == spread_custom);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            src_q <= 1'b0;
            num_q <= 24'h000000;
            spread_q <= spread_custom;
            custom_q <= 1'b0;
        end else begin
            src_q <= src_d;
            num_q <= num_d;
            spread_q <= spread_d;
            custom_q <= custom_d;
        end
    end

    // ======================================================================
    // Outputs
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign oe_active = oe_act_q;
    assign clock_out_a_en = a_en_q;
    assign clock_out_b_en = b_en_q;
    assign clock_out_b_invert = b_inv_q;
    assign clock_out_c_en = c_en_q;
    assign clock_out_d_en = d_en_q;
    assign clock_out_d_invert = d_inv_q;
    assign pair2_source_select = src_q;
    assign frac_divider1_numerator = num_q;
    assign spread_preset = spread_q;
    assign spread_custom_sel = custom_q;

endmodule

// file: ccr_top_chk.sv
// Port-level assertions for the output configuration register bank.
module ccr_top_chk
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // Fuse and neighbour inputs
    input wire logic fuse_load,
    input wire logic [15:0] fuse_numlo,
    input wire logic [7:0] numerator_high,
    input wire logic [2:0] pair1_format,
    // Steering outputs
    input wire logic oe_active,
    input wire logic clock_out_a_en,
    input wire logic clock_out_b_en,
    input wire logic clock_out_b_invert,
    input wire logic clock_out_c_en,
    input wire logic clock_out_d_en,
    input wire logic pair2_source_select,
    input wire logic [23:0] frac_divider1_numerator,
    input wire ccr_spread_e spread_preset,
    input wire logic spread_custom_sel
);
    // ======================================================================
    // Helpers
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A fuse load in the same cycle drops the write, so it is excluded.
    wire logic ctl_wr = reg_wr && reg_addr == 8'h07 && !fuse_load;
    wire logic num_wr = reg_wr && reg_addr == 8'h08 && !fuse_load;

    // ======================================================================
    // Assertions
    AST_PAIR2_OFF: assert property (ctl_wr && !reg_wdata[8] |->
        ##2 !clock_out_c_en && !clock_out_d_en) else $error("pair2 on");
    AST_SRC: assert property (ctl_wr |->
        ##2 pair2_source_select == $past(reg_wdata[7], 2)) else $error("src");
    AST_NUM_WR: assert property (num_wr |->
        ##2 frac_divider1_numerator[15:0] == $past(reg_wdata, 2))
        else $error("numerator low");
    AST_NUM_HI: assert property (1 |=>
        frac_divider1_numerator[23:16] == $past(numerator_high))
        else $error("numerator high");
    AST_FUSE_RD: assert property (fuse_load ##1 reg_rd &&
        reg_addr == 8'h08 |=> reg_rdata == $past(fuse_numlo, 2))
        else $error("fuse load");
    AST_RVALID: assert property (reg_rd |=> reg_rvalid)
        else $error("no rvalid");
    AST_EN_OE: assert property (clock_out_a_en || clock_out_c_en
        |-> oe_active) else $error("enable without oe");
    AST_B_INV: assert property (1 |=>
        clock_out_b_invert == ($past(pair1_format) == 3'h6))
        else $error("invert");
    AST_FMT_LOW: assert property (pair1_format < 3'h4 |=>
        !clock_out_a_en && !clock_out_b_en) else $error("reserved fmt");
    AST_CUSTOM: assert property (spread_custom_sel |->
        spread_preset == spread_custom) else $error("custom");
    cover property (ctl_wr);
    cover property (fuse_load ##1 reg_rd);
    cover property (spread_preset == spread_reserved);
endmodule

bind ccr_top ccr_top_chk u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .reg_rvalid, .fuse_load, .fuse_numlo,
    .numerator_high, .pair1_format, .oe_active, .clock_out_a_en,
    .clock_out_b_en, .clock_out_b_invert, .clock_out_c_en, .clock_out_d_en,
    .pair2_source_select, .frac_divider1_numerator, .spread_preset,
    .spread_custom_sel);

// file: ccr_top_tb.sv
// Self-checking testbench of the output configuration register bank.
module ccr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, fuse_load, oe_pin, reg_wr, reg_rd, reg_rvalid, oe_active;
    logic [15:0] fuse_outctl, fuse_numlo, fuse_cfgid, reg_wdata, reg_rdata;
    logic [7:0] numerator_high, reg_addr;
    logic [2:0] pair1_format, spread_preset, f;
    logic clock_out_a_en, clock_out_b_en, clock_out_b_invert, clock_out_c_en;
    logic clock_out_d_en, clock_out_d_invert, pair2_source_select;
    logic spread_custom_sel, v, s, en, pol, on;
    logic [23:0] frac_divider1_numerator;
    logic [15:0] q, d, nl, rv[4];
    logic [7:0] a, ra[4] = '{8'h07, 8'h08, 8'h09, 8'h0A};
    int n_mismatch = 0, samples_checked = 0, cyc = 0;

    ccr_top uut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid, .fuse_load, .fuse_outctl, .fuse_numlo,
        .fuse_cfgid, .numerator_high, .pair1_format, .oe_pin, .oe_active,
        .clock_out_a_en, .clock_out_b_en, .clock_out_b_invert,
        .clock_out_c_en, .clock_out_d_en, .clock_out_d_invert,
        .pair2_source_select, .frac_divider1_numerator, .spread_preset,
        .spread_custom_sel);
    ccr_host host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid);

    // ======================================================================
    // Checking helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check_regs();
        for (int i = 0; i < 4; i++) begin
            host.rd(ra[i], q, v);
            chk(24'({v, q}), 24'({1'b1, rv[i]}));
        end
    endtask
    function automatic logic [2:0] pins(input logic [2:0] c, input logic o);
        pins = {o & (c == 3'h4 || c > 3'h5), o & c > 3'h4, c == 3'h6};
    endfunction
    function automatic logic [3:0] spr(input logic [2:0] c);
        spr = {(c > 3'h4) ? 3'h5 : c, c == 3'h0};
    endfunction

    // ======================================================================
    // Clock, timeout and tests
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        {rst, fuse_load, fuse_outctl, fuse_numlo, fuse_cfgid} = {1'b1, 49'h0};
        {numerator_high, pair1_format, oe_pin} = '0;
        void'($urandom(27364));
        repeat (2) @(negedge clk);
        rst = 0;
        rv = '{16'h5D1F, 16'hC28F, 16'h3000, 16'h0000};
        host.wr(8'h0A, 16'hFFFF);
        check_regs();
        chk(24'({oe_active, clock_out_c_en, clock_out_d_en,
            clock_out_d_invert, spread_custom_sel}), 24'h1D);
        $display("reset test done");
        nl = 16'hC28F;
        repeat (20) begin
            {numerator_high, d} = 24'($urandom);
            a = 8'h07 + 8'($urandom_range(2));
            host.wr(a, d);
            host.rd(a, q, v);
            if (a == 8'h08) nl = d;
            d = d & (a == 8'h07 ? 16'h7F9F : a == 8'h09 ? 16'hFE00 : 16'hFFFF);
            chk(24'(q), 24'(d));
            chk(frac_divider1_numerator, {numerator_high, nl});
        end
        $display("storage test done");
        for (int k = 0; k < 64; k++) begin
            {oe_pin, pol, en, f} = 6'(k);
            pair1_format = f;
            s = 1'($urandom);
            host.wr(8'h07, {7'h00, en, s, 2'h0, f, ~en, pol});
            @(negedge clk);
            on = oe_pin ^ pol;
            chk(24'({oe_active, pair2_source_select}), 24'({on, s}));
            chk(24'({clock_out_c_en, clock_out_d_en, clock_out_d_invert}),
                24'(pins(f, en & on)));
            chk(24'({clock_out_a_en, clock_out_b_en, clock_out_b_invert}),
                24'(pins(f, ~en & on)));
        end
        $display("format test done");
        for (int k = 0; k < 8; k++) begin
            host.wr(8'h09, {4'($urandom), 3'(k), 9'h000});
            @(negedge clk);
            chk(24'({spread_preset, spread_custom_sel}),
                24'(spr(3'(k))));
        end
        $display("spread test done");
        {fuse_outctl, fuse_numlo, fuse_cfgid} = 48'({$urandom, $urandom});
        fork
            host.wr(8'h08, ~fuse_numlo);
            begin
                @(negedge clk);
                fuse_load = 1;
                @(negedge clk);
                fuse_load = 0;
            end
        join
        rv = '{fuse_outctl & 16'h7FFF, fuse_numlo, fuse_cfgid, 16'h0000};
        check_regs();
        fuse_numlo = ~fuse_numlo;
        fuse_load = 1;
        fork
            host.rd(8'h08, q, v);
            begin
                @(negedge clk);
                fuse_load = 0;
            end
        join
        chk(24'({v, q}), 24'({1'b1, fuse_numlo}));
        $display("fuse test done");
        final_report();
    end
endmodule
